//--- inc/loader_pkg.sv
// Shared constants and types of the parallel configuration loader
`default_nettype none
package loader_pkg;

	// Mode strap codes of the parallel load port
	localparam logic [3:0] MODE_X1   = 4'h3;
	localparam logic [3:0] MODE_X8   = 4'h4;
	localparam logic [3:0] MODE_X16  = 4'h5;
	localparam logic [3:0] MODE_X32  = 4'h6;
	localparam logic [3:0] MODE_X128 = 4'h7;

	localparam int BUS_W      = 32;
	localparam int FIFO_DEPTH = 8;

	// Lane masks per width
	localparam logic [31:0] MASK_X1  = 32'h0000_0001;
	localparam logic [31:0] MASK_X8  = 32'h0000_00ff;
	localparam logic [31:0] MASK_X16 = 32'h0000_ffff;
	localparam logic [31:0] MASK_X32 = 32'hffff_ffff;
	localparam logic [31:0] NOP_WORD = 32'h0000_0000;

	// Sequence step lengths in clock cycles
	localparam logic [7:0] CLEAR_CYCLES   = 8'h20;
	localparam logic [7:0] FINISH_CYCLES  = 8'h10;
	localparam logic [7:0] RELEASE_CYCLES = 8'h08;
	localparam logic [7:0] ENABLE_CYCLES  = 8'h08;

	// Default count of non-empty words in one bitstream
	localparam logic [31:0] LOAD_WORDS_DEFAULT = 32'h0000_0400;

	typedef enum logic [1:0] {
		WIDTH_X1,
		WIDTH_X8,
		WIDTH_X16,
		WIDTH_X32
	} lane_width_t;

	typedef struct packed {
		lane_width_t width;
		logic [31:0] data;
	} cfg_word_t;

endpackage
`default_nettype wire

//--- core/cpu_parallel_config_loader.sv
// Parallel host load port with its word FIFO
`timescale 1ns/1ns
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 34,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             do_wr;
	logic             do_rd;

	assign in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	// Storage entries
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_reg[i] <= '0;
			end else if (do_wr && wr_ptr_reg[AW-1:0] == AW'(i)) begin
				mem_reg[i] <= in_data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
		end else if (do_wr) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr_reg <= '0;
		end else if (do_rd) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

module cpu_parallel_config_loader #(
	parameter logic [31:0] LOAD_WORDS = loader_pkg::LOAD_WORDS_DEFAULT
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [3:0]        mode_strap_pins,
	input  wire logic              host_select_n,
	input  wire logic [31:0]       host_data_bus_in,
	output logic [31:0]            host_data_bus_out,
	output logic [31:0]            host_data_bus_oe,
	output logic                   data_drive_indicator,
	output logic                   clear_complete_flag,
	output logic                   load_complete_flag,
	output logic                   operational_mode_flag,
	output logic                   fabric_reset_n,
	output logic                   overrun_flag,
	output logic                   cfg_valid,
	input  wire logic              cfg_ready,
	output loader_pkg::cfg_word_t  cfg_word
);
	typedef enum logic [2:0] {
		ST_STRAP,
		ST_CLEAR,
		ST_LOAD,
		ST_DRAIN,
		ST_FINISH,
		ST_RELEASE,
		ST_ENABLE,
		ST_USER
	} seq_state_t;

	seq_state_t            state_reg;
	logic [7:0]            cnt_reg;
	logic [31:0]           words_reg;
	loader_pkg::lane_width_t width_reg;
	logic                  width_ok_reg;
	logic                  sel_n_reg;
	logic [31:0]           data_reg;
	logic [31:0]           lane_mask;
	loader_pkg::cfg_word_t push_word;
	loader_pkg::cfg_word_t fifo_word;
	logic                  push;
	logic                  fifo_ready;
	logic                  fifo_valid;
	logic                  fifo_take;

	// Lane mask for the strapped width
	always_comb begin
		case (width_reg)
			loader_pkg::WIDTH_X1:  lane_mask = loader_pkg::MASK_X1;
			loader_pkg::WIDTH_X8:  lane_mask = loader_pkg::MASK_X8;
			loader_pkg::WIDTH_X16: lane_mask = loader_pkg::MASK_X16;
			default:               lane_mask = loader_pkg::MASK_X32;
		endcase
	end

	// Strap caught after reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			width_reg    <= loader_pkg::WIDTH_X32;
			width_ok_reg <= 1'b0;
		end else if (state_reg == ST_STRAP) begin
			width_ok_reg <= 1'b1;
			case (mode_strap_pins)
				loader_pkg::MODE_X1:  width_reg <= loader_pkg::WIDTH_X1;
				loader_pkg::MODE_X8:  width_reg <= loader_pkg::WIDTH_X8;
				loader_pkg::MODE_X16: width_reg <= loader_pkg::WIDTH_X16;
				loader_pkg::MODE_X32: width_reg <= loader_pkg::WIDTH_X32;
				default:              width_ok_reg <= 1'b0;
			endcase
		end
	end

	// Input sampling on the rising edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_n_reg <= 1'b1;
			data_reg  <= loader_pkg::NOP_WORD;
		end else begin
			sel_n_reg <= host_select_n;
			data_reg  <= host_data_bus_in & lane_mask;
		end
	end

	// Only selected, non-empty words in the load step are taken
	assign push = (state_reg == ST_LOAD) && !sel_n_reg
		&& (data_reg != loader_pkg::NOP_WORD);
	assign push_word.width = width_reg;
	assign push_word.data  = data_reg;

	word_fifo #(
		.WIDTH ($bits(loader_pkg::cfg_word_t)),
		.DEPTH (loader_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (push_word),
		.out_valid (fifo_valid),
		.out_ready (fifo_take),
		.out_data  (fifo_word)
	);

	assign fifo_take = !cfg_valid || cfg_ready;

	// Output register stage toward the decoder
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_valid <= 1'b0;
			cfg_word  <= '0;
		end else if (fifo_take) begin
			cfg_valid <= fifo_valid;
			cfg_word  <= fifo_word;
		end
	end

	// Word lost when the decoder stalls the FIFO full
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_flag <= 1'b0;
		end else if (push && !fifo_ready) begin
			overrun_flag <= 1'b1;
		end
	end

	// Taken word count, words lost to overrun included
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			words_reg <= '0;
		end else if (push) begin
			words_reg <= words_reg + 32'h0000_0001;
		end
	end

	// Sequence steps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_STRAP;
			cnt_reg   <= '0;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			case (state_reg)
				ST_STRAP: begin
					cnt_reg <= '0;
					if (width_ok_reg) begin
						state_reg <= ST_CLEAR;
					end
				end
				ST_CLEAR: begin
					if (cnt_reg == loader_pkg::CLEAR_CYCLES - 8'h01) begin
						state_reg <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					cnt_reg <= '0;
					if (push && words_reg == LOAD_WORDS - 32'h0000_0001) begin
						state_reg <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					cnt_reg <= '0;
					if (!fifo_valid && !cfg_valid) begin
						state_reg <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					if (cnt_reg == loader_pkg::FINISH_CYCLES - 8'h01) begin
						cnt_reg   <= '0;
						state_reg <= ST_RELEASE;
					end
				end
				ST_RELEASE: begin
					if (cnt_reg == loader_pkg::RELEASE_CYCLES - 8'h01) begin
						cnt_reg   <= '0;
						state_reg <= ST_ENABLE;
					end
				end
				ST_ENABLE: begin
					if (cnt_reg == loader_pkg::ENABLE_CYCLES - 8'h01) begin
						state_reg <= ST_USER;
					end
				end
				ST_USER: begin
					cnt_reg <= '0;
				end
				default: begin
					state_reg <= ST_STRAP;
				end
			endcase
		end
	end

	// Milestone flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_complete_flag   <= 1'b0;
			load_complete_flag    <= 1'b0;
			fabric_reset_n        <= 1'b0;
			operational_mode_flag <= 1'b0;
		end else begin
			clear_complete_flag   <= clear_complete_flag || state_reg == ST_LOAD;
			load_complete_flag    <= load_complete_flag || state_reg == ST_RELEASE;
			fabric_reset_n        <= fabric_reset_n || state_reg == ST_ENABLE;
			operational_mode_flag <= operational_mode_flag || state_reg == ST_USER;
		end
	end

	// Data lanes are only ever input
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_drive_indicator <= 1'b1;
			host_data_bus_out    <= '0;
			host_data_bus_oe     <= '0;
		end else begin
			data_drive_indicator <= host_select_n;
			host_data_bus_out    <= '0;
			host_data_bus_oe     <= '0;
		end
	end

	localparam int CLEAR_BOUND = int'(loader_pkg::CLEAR_CYCLES) + 8;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_ignore_deselect: assert property ($past(host_select_n) |-> !push)
		else $error("word taken while deselected");
	chk_nop_dropped: assert property ($past(host_data_bus_in) == 32'h0000_0000 |-> !push)
		else $error("empty word taken");
	chk_drive_low: assert property (!$past(host_select_n) |-> !data_drive_indicator)
		else $error("drive indicator high while selected");
	chk_lane_mask: assert property ((push && width_reg == loader_pkg::WIDTH_X8) |->
		push_word.data == {24'h000000, $past(host_data_bus_in[7:0])})
		else $error("upper lanes leak in x8 mode");
	chk_clear_time: assert property ($rose(state_reg == ST_CLEAR) |->
		!clear_complete_flag ##[1:CLEAR_BOUND] clear_complete_flag)
		else $error("clear complete late");
	chk_done_order: assert property ($rose(load_complete_flag) |-> clear_complete_flag
		&& !fabric_reset_n)
		else $error("load complete out of order");
	chk_user_order: assert property ($rose(operational_mode_flag) |->
		fabric_reset_n && $past(fabric_reset_n, 8))
		else $error("operational before fabric release");
	chk_strap_refused: assert property ((state_reg != ST_STRAP && !width_ok_reg) |-> 0)
		else $error("unsupported width left strap step");
	chk_bus_input: assert property (host_data_bus_oe == 32'h0000_0000)
		else $error("data lanes driven");

	cov_word_push:  cover property (push);
	cov_load_done:  cover property ($rose(load_complete_flag));
	cov_nop_hold:   cover property (!sel_n_reg && state_reg == ST_USER);
	cov_user_mode:  cover property ($rose(operational_mode_flag));
endmodule

`default_nettype wire

//--- verif/host_feeder.sv
// Host processor model feeding bitstream words to the load port
`timescale 1ns/1ns
`default_nettype none

module host_feeder (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clear_complete_flag,
	input  wire logic        nop_mode,
	input  wire logic        hold_low,
	output logic             host_select_n,
	output logic [31:0]      host_data_bus_in
);
	logic [31:0] words[$];
	int          seed = 60035;
	logic        paused;

	localparam int WAIT_GAP = 300;

	initial begin
		host_select_n = 1'b1;
		host_data_bus_in = 32'h0000_0000;
		forever begin
			@(negedge clk);
			if (rst_n && clear_complete_flag && words.size() != 0) begin
				// Settle time after clear before selecting
				repeat (5 + ($random(seed) & 3)) @(negedge clk);
				paused = 1'b0;
				while (words.size() != 0) begin
					// Long deselected wait mid-stream, lanes busy
					if (!paused && words.size() == 6) begin
						paused = 1'b1;
						host_select_n = 1'b1;
						repeat (WAIT_GAP) begin
							host_data_bus_in = $random(seed);
							@(negedge clk);
						end
					end
					host_select_n = 1'b0;
					if (nop_mode && ($random(seed) & 3) == 0)
						host_data_bus_in = 32'h0000_0000;
					else
						host_data_bus_in = words.pop_front();
					@(negedge clk);
				end
				// Release select or keep it low with empty words
				host_select_n = hold_low ? 1'b0 : 1'b1;
				host_data_bus_in = hold_low ? 32'h0000_0000 : ~host_data_bus_in;
				while (rst_n) begin
					@(negedge clk);
					if (!hold_low)
						host_data_bus_in = ~host_data_bus_in;
				end
				host_select_n = 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

//--- verif/cpu_parallel_config_loader_test.sv
// Self-checking bench of the parallel configuration loader
`timescale 1ns/1ns
`default_nettype none

module cpu_parallel_config_loader_test;
	localparam logic [31:0] NW = 32'h0000_000c;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [3:0]            strap = 4'h3;
	logic                  nop_mode = 1'b0;
	logic                  hold_low = 1'b0;
	logic                  stall = 1'b0;
	logic                  cready = 1'b1;
	logic                  sel_q = 1'b1;
	logic                  sel_n, ddi, clr, done, oper, fab_n, ovr, cv;
	logic [31:0]           din, dout, doe;
	loader_pkg::cfg_word_t cw;
	logic [33:0]           got[$];
	logic [33:0]           exp_q[$];
	int                    seed = 60035;
	int                    err_total = 0;
	int                    total_checks = 0;

	always #5 clk = ~clk;

	cpu_parallel_config_loader #(.LOAD_WORDS(NW)) dut_u (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.mode_strap_pins       (strap),
		.host_select_n         (sel_n),
		.host_data_bus_in      (din),
		.host_data_bus_out     (dout),
		.host_data_bus_oe      (doe),
		.data_drive_indicator  (ddi),
		.clear_complete_flag   (clr),
		.load_complete_flag    (done),
		.operational_mode_flag (oper),
		.fabric_reset_n        (fab_n),
		.overrun_flag          (ovr),
		.cfg_valid             (cv),
		.cfg_ready             (cready),
		.cfg_word              (cw)
	);

	host_feeder host_u (
		.clk                 (clk),
		.rst_n               (rst_n),
		.clear_complete_flag (clr),
		.nop_mode            (nop_mode),
		.hold_low            (hold_low),
		.host_select_n       (sel_n),
		.host_data_bus_in    (din)
	);

	task automatic check(input string what, input logic [33:0] exp, input logic [33:0] seen);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] lane_mask(input logic [3:0] m);
		case (m)
			loader_pkg::MODE_X1: lane_mask = loader_pkg::MASK_X1;
			loader_pkg::MODE_X8: lane_mask = loader_pkg::MASK_X8;
			loader_pkg::MODE_X16: lane_mask = loader_pkg::MASK_X16;
			default: lane_mask = loader_pkg::MASK_X32;
		endcase
	endfunction

	always @(posedge clk) begin
		sel_q <= sel_n;
		if (cv === 1'b1 && cready)
			got.push_back(cw);
	end

	always @(negedge clk) begin
		cready <= stall ? 1'b0 : (($random(seed) & 3) != 0);
		if (rst_n) begin
			check("drive indicator", {33'h0, sel_q}, {33'h0, ddi});
			check("lane drive", 34'h0, {2'h0, doe | dout});
		end
	end

	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic run(input logic [3:0] m, input logic nm, input logic hl, input logic st);
		logic [31:0] w;
		int          n;
		rst_n = 1'b0;
		strap = m;
		nop_mode = nm;
		hold_low = hl;
		stall = st;
		got.delete();
		exp_q.delete();
		host_u.words.delete();
		repeat (12) @(negedge clk);
		for (int i = 0; i < NW; i++) begin
			w = $random(seed);
			if ((w & lane_mask(m)) == 32'h0)
				w[0] = 1'b1;
			host_u.words.push_back(w);
			exp_q.push_back({2'(m - 4'h3), w & lane_mask(m)});
		end
		rst_n = 1'b1;
		wait_hi(clr, 200, n);
		if (m > loader_pkg::MODE_X32) begin
			check("strap refused", 34'h0, {33'h0, clr});
			check("no output", 34'h0, 34'(got.size()));
			return;
		end
		check("clear flag", 34'h1, {33'h0, clr});
		check("clear gap", 34'(loader_pkg::CLEAR_CYCLES) + 34'd3, 34'(n));
		check("early done", 34'h0, {33'h0, done});
		if (st) begin
			while (host_u.words.size() != 0)
				@(negedge clk);
			repeat (4) @(negedge clk);
			stall = 1'b0;
			repeat (40) @(negedge clk);
			check("overrun set", 34'h1, {33'h0, ovr});
			check("words lost", 34'h1, {33'h0, got.size() < NW});
		end else begin
			wait_hi(done, 1000, n);
			check("done flag", 34'h1, {33'h0, done});
			check("fabric held", 34'h0, {33'h0, fab_n});
			wait_hi(fab_n, 50, n);
			check("release gap", 34'(loader_pkg::RELEASE_CYCLES), 34'(n));
			check("oper early", 34'h0, {33'h0, oper});
			wait_hi(oper, 50, n);
			check("oper gap", 34'(loader_pkg::ENABLE_CYCLES), 34'(n));
			check("no overrun", 34'h0, {33'h0, ovr});
			check("word count", 34'(NW), 34'(got.size()));
		end
		for (int i = 0; i < got.size() && i < exp_q.size(); i++)
			check("word", exp_q[i], got[i]);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		run(loader_pkg::MODE_X8, 1'b0, 1'b0, 1'b0);
		run(loader_pkg::MODE_X1, 1'b1, 1'b0, 1'b0);
		run(loader_pkg::MODE_X16, 1'b0, 1'b1, 1'b0);
		run(loader_pkg::MODE_X32, 1'b1, 1'b1, 1'b0);
		run(loader_pkg::MODE_X32, 1'b0, 1'b0, 1'b1);
		run(loader_pkg::MODE_X128, 1'b0, 1'b0, 1'b0);
		tally_and_finish();
	end

	initial begin
		#200000;
		err_total++;
		$display("MISMATCH watchdog expected finish seen hang");
		tally_and_finish();
	end
endmodule

`default_nettype wire
